/* sdc_params.svh */
// Timing counts, command codes and field positions of the SDRAM controller.
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH
`define SDC_CLK_MHZ 125
`define SDC_T_RC 12
`define SDC_T_RC1 12
`define SDC_T_RAS 12
`define SDC_T_RP 12
`define SDC_T_RCD 3
`define SDC_T_RRD 4
`define SDC_T_DPL 2
`define SDC_T_DAL 6
`define SDC_T_RSC 2
`define SDC_BURST 4
`define SDC_CAS_LAT 3
`define SDC_TREF_MS 50
`define SDC_REF_ROWS 4096
`define SDC_REF_CYC ((`SDC_TREF_MS * 1000 * `SDC_CLK_MHZ) / `SDC_REF_ROWS)
`define SDC_TPWR_US 100
`define SDC_PWR_CYC (`SDC_TPWR_US * `SDC_CLK_MHZ)
`define SDC_INIT_REFS 8
`define SDC_MODE_WORD 14'h0032
`define SDC_A10 10
`define SDC_CMD_NOP 4'h7
`define SDC_CMD_ACT 4'h3
`define SDC_CMD_RD 4'h5
`define SDC_CMD_WR 4'h4
`define SDC_CMD_PRE 4'h2
`define SDC_CMD_REF 4'h1
`define SDC_CMD_MRS 4'h0
`endif

/* sdc_pkg.sv */
// Types of the SDRAM controller: sequencer states and the state record.
package sdc_pkg;
  typedef enum logic [2:0] {
    S_PWR, S_IPRE, S_IREF, S_IMRS, S_IDLE, S_RCD, S_DATA
  } sdc_state_t;

  typedef struct packed {
    sdc_state_t    st;
    logic [4:0]    gap;
    logic [3:0]    age;
    logic [10:0]   rtmr;
    logic          rpend;
    logic [13:0]   icnt;
    logic [1:0]    wcnt;
    logic          wr;
    logic          ap;
    logic [13:0]   row;
    logic [7:0]    col;
    logic [127:0]  wdat;
    logic          cke;
    logic [3:0]    cmd;
    logic [13:0]   addr;
    logic [31:0]   dq_o;
    logic          dq_oe;
    logic [8:0]    rdp;
    logic [31:0]   dq_s1;
    logic [31:0]   dq_s2;
    logic [31:0]   rdat;
    logic          rvld;
  } sdc_regs_t;
endpackage

/* sdc_ctrl.sv */
// SDRAM command sequencer with power-up, refresh and burst-four accesses.
`timescale 1ns/1ns
`include "sdc_params.svh"
module sdc_ctrl #(
  parameter int PWRUP_CYC = `SDC_PWR_CYC,
  parameter int INIT_REFS = `SDC_INIT_REFS
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire logic          req_write,
  input  wire logic          req_autopre,
  input  wire logic [21:0]   req_addr,
  input  wire logic [127:0]  req_wdata,
  output logic [31:0]        rd_data,
  output logic               rd_valid,
  output logic               init_done,
  output logic               mem_clk_en,
  output logic               mem_chip_sel_n,
  output logic               mem_row_strobe_n,
  output logic               mem_col_strobe_n,
  output logic               mem_write_en_n,
  output logic               mem_byte_mask,
  output logic [13:0]        mem_addr,
  input  wire logic [31:0]   mem_dq_in,
  output logic [31:0]        mem_dq_out,
  output logic               mem_dq_oe
);
  import sdc_pkg::*;

  if (PWRUP_CYC < 1 || PWRUP_CYC > 16383) begin : g_bad_pwr
    $error("PWRUP_CYC must lie in 1..16383");
  end
  if (INIT_REFS < 1 || INIT_REFS > 16383) begin : g_bad_refs
    $error("INIT_REFS must lie in 1..16383");
  end

  localparam logic [13:0] PWR_LAST = 14'(PWRUP_CYC - 1);
  localparam logic [13:0] REFS_LAST = 14'(INIT_REFS - 1);
  localparam logic [10:0] REF_LAST = 11'(`SDC_REF_CYC - 1);
  localparam logic [3:0] AGE_ACT = 4'(`SDC_T_RC - 1);
  localparam logic [3:0] AGE_PRE = 4'(`SDC_T_RAS - 1);
  localparam logic [3:0] AGE_RRD = 4'(`SDC_T_RRD - 1);

  sdc_regs_t q;
  sdc_regs_t d;

  function automatic logic [4:0] gap_of(input int n);
    return 5'(n - 1);
  endfunction

  logic age_ok;
  logic ref_hit;

  always_comb begin
    d = q;
    d.cmd = `SDC_CMD_NOP;
    d.addr = q.addr;
    d.rvld = q.rdp[`SDC_CAS_LAT + 2] | q.rdp[`SDC_CAS_LAT + 3] |
             q.rdp[`SDC_CAS_LAT + 4] | q.rdp[`SDC_CAS_LAT + 5];
    d.rdat = q.dq_s2;
    d.dq_s1 = mem_dq_in;
    d.dq_s2 = q.dq_s1;
    d.rdp = {q.rdp[7:0], 1'b0};
    d.gap = (q.gap != 5'h00) ? q.gap - 5'h01 : 5'h00;
    d.age = (q.age != 4'hf) ? q.age + 4'h1 : 4'hf;
    // Activate needs both the row cycle and the bank-to-bank gap.
    age_ok = (q.age >= AGE_ACT) && (q.age >= AGE_RRD);
    ref_hit = (q.rtmr == 11'h000);
    d.rtmr = ref_hit ? REF_LAST : q.rtmr - 11'h001;
    d.rpend = q.rpend | ref_hit;
    req_ready = (q.st == S_IDLE) && !q.rpend && (q.gap == 5'h00) && age_ok;
    unique case (q.st)
      S_PWR: begin
        d.cke = 1'b1;
        d.icnt = q.icnt + 14'h0001;
        if (q.icnt == PWR_LAST) begin
          d.cmd = `SDC_CMD_PRE;
          d.addr = 14'h0000;
          d.addr[`SDC_A10] = 1'b1;
          d.gap = gap_of(`SDC_T_RP);
          d.icnt = 14'h0000;
          d.st = S_IPRE;
        end
      end
      S_IPRE: d.st = S_IREF;
      S_IREF: begin
        if (q.gap == 5'h00) begin
          d.cmd = `SDC_CMD_REF;
          d.gap = gap_of(`SDC_T_RC1);
          d.rpend = ref_hit;
          d.icnt = q.icnt + 14'h0001;
          if (q.icnt == REFS_LAST) begin
            d.st = S_IMRS;
          end
        end
      end
      S_IMRS: begin
        if (q.gap == 5'h00) begin
          d.cmd = `SDC_CMD_MRS;
          d.addr = `SDC_MODE_WORD;
          d.gap = gap_of(`SDC_T_RSC);
          d.st = S_IDLE;
        end
      end
      S_IDLE: begin
        if (q.gap == 5'h00 && age_ok && q.rpend) begin
          d.cmd = `SDC_CMD_REF;
          d.gap = gap_of(`SDC_T_RC1);
          d.rpend = ref_hit; // Set wins over clear.
        end else if (req_valid && req_ready) begin
          d.cmd = `SDC_CMD_ACT;
          d.addr = req_addr[21:8];
          d.row = req_addr[21:8];
          d.col = req_addr[7:0];
          d.wr = req_write;
          d.ap = req_autopre;
          d.wdat = req_wdata;
          d.age = 4'h0;
          d.gap = gap_of(`SDC_T_RCD);
          d.st = S_RCD;
        end
      end
      S_RCD: begin
        if (q.gap == 5'h00) begin
          d.cmd = q.wr ? `SDC_CMD_WR : `SDC_CMD_RD;
          d.addr = {q.row[13:12], 4'h0, q.col};
          d.addr[`SDC_A10] = q.ap;
          d.st = S_DATA;
          if (q.wr) begin
            d.dq_o = q.wdat[31:0];
            d.dq_oe = 1'b1;
            d.wcnt = 2'h1;
            d.gap = q.ap ? gap_of(`SDC_BURST - 1 + `SDC_T_DAL)
                         : gap_of(`SDC_BURST - 1 + `SDC_T_DPL);
          end else begin
            d.rdp = {q.rdp[7:0], 1'b1};
            d.gap = q.ap ? gap_of(`SDC_BURST + `SDC_T_RP)
                         : gap_of(`SDC_BURST);
          end
        end
      end
      S_DATA: begin
        if (q.wcnt != 2'h0) begin
          d.dq_o = q.wdat[32 * q.wcnt +: 32];
          d.wcnt = q.wcnt + 2'h1;
        end else begin
          d.dq_oe = 1'b0;
        end
        if (q.gap == 5'h00 && q.wcnt == 2'h0) begin
          if (q.ap) begin
            d.st = S_IDLE;
          end else if (q.age >= AGE_PRE) begin
            d.cmd = `SDC_CMD_PRE;
            d.addr = {q.row[13:12], 12'h000};
            d.gap = gap_of(`SDC_T_RP);
            d.st = S_IDLE;
          end
        end
      end
      default: d.st = S_PWR;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= S_PWR;
      q.age <= 4'hf;
      q.rtmr <= REF_LAST;
      q.cmd <= `SDC_CMD_NOP;
    end else if (ce) begin
      q <= d;
    end
  end

  assign rd_data = q.rdat;
  assign rd_valid = q.rvld;
  assign init_done = (q.st == S_IDLE) || (q.st == S_RCD) || (q.st == S_DATA);
  assign mem_clk_en = q.cke;
  assign {mem_chip_sel_n, mem_row_strobe_n} = q.cmd[3:2];
  assign {mem_col_strobe_n, mem_write_en_n} = q.cmd[1:0];
  assign mem_byte_mask = 1'b0;
  assign mem_addr = q.addr;
  assign mem_dq_out = q.dq_o;
  assign mem_dq_oe = q.dq_oe;

  logic act_p, ref_p, pre_p, rw_p, wr_p, mrs_p;
  assign act_p = (q.cmd == `SDC_CMD_ACT);
  assign ref_p = (q.cmd == `SDC_CMD_REF);
  assign pre_p = (q.cmd == `SDC_CMD_PRE);
  assign wr_p = (q.cmd == `SDC_CMD_WR);
  assign rw_p = wr_p || (q.cmd == `SDC_CMD_RD);
  assign mrs_p = (q.cmd == `SDC_CMD_MRS);

  default clocking cb @(posedge sys_clk iff ce); endclocking
  default disable iff (!rst_n);

  act_to_act_a: assert property (act_p |=> (!act_p && !ref_p) [*8] ##1
    (!act_p && !ref_p) [*3]) else $error("Activate spacing too short.");
  ref_to_any_a: assert property (ref_p |=> (!act_p && !ref_p) [*8] ##1
    (!act_p && !ref_p) [*3]) else $error("Refresh spacing too short.");
  row_open_a: assert property (act_p |=> !pre_p [*8] ##1 !pre_p [*3])
    else $error("Row closed too early.");
  pre_to_act_a: assert property (pre_p |=> !act_p [*8] ##1
    !act_p [*3]) else $error("Activate too soon after precharge.");
  act_to_rw_a: assert property (act_p |=> !rw_p [*2])
    else $error("Column command too soon after activate.");
  bank_gap_a: assert property (act_p |=> !act_p [*3])
    else $error("Bank activates too close.");
  wr_to_pre_a: assert property (wr_p && !mem_addr[`SDC_A10] |=>
    !pre_p [*4]) else $error("Precharge too soon after write data.");
  wr_ap_gap_a: assert property (wr_p && mem_addr[`SDC_A10] |=>
    (!act_p && !ref_p) [*8]) else $error("Activate too soon after write.");
  mrs_gap_a: assert property (mrs_p |=> q.cmd == `SDC_CMD_NOP)
    else $error("Command too soon after mode set.");
  rd_burst_a: assert property ((q.cmd == `SDC_CMD_RD) |->
    ##6 rd_valid [*4])
    else $error("Read burst not returned at CAS latency three.");
  wr_burst_a: assert property (wr_p |-> mem_dq_oe [*4] ##1
    !mem_dq_oe) else $error("Write burst not four words.");

  read_seen_c: cover property ((q.cmd == `SDC_CMD_RD) ##6 rd_valid [*4]);
  write_ap_c: cover property (wr_p && mem_addr[`SDC_A10]);
  refresh_c: cover property (ref_p && init_done);
  pre_after_wr_c: cover property (wr_p ##9 pre_p);
endmodule

/* sdc_mem_model.sv */
// Behavioural SDRAM that stores write bursts and returns reads.
`timescale 1ns/1ns
`include "sdc_params.svh"
module sdc_mem_model (
  input  wire logic        sys_clk,
  input  wire logic [3:0]  cmd,
  input  wire logic [13:0] addr,
  input  wire logic [31:0] dq_w,
  output logic      [31:0] dq_r
);
  logic [31:0] mem [16];
  logic [1:0]  bank = 2'h0;
  logic [2:0]  wc = 3'h0;
  logic [2:0]  rc = 3'h0;
  logic [31:0] last = 32'h0;
  // Read words appear three cycles after the read command.
  always_comb dq_r = (rc >= 3'h3) ? mem[{bank, 2'(rc - 3'h3)}] : ~last;
  always @(posedge sys_clk) begin
    last <= dq_r;
    if (cmd == `SDC_CMD_WR) begin
      mem[{addr[13:12], 2'h0}] <= dq_w;
      bank <= addr[13:12];
      wc <= 3'h1;
    end else if (wc != 3'h0) begin
      mem[{bank, wc[1:0]}] <= dq_w;
      wc <= (wc == 3'h3) ? 3'h0 : wc + 3'h1;
    end
    if (cmd == `SDC_CMD_RD) begin
      bank <= addr[13:12];
      rc <= 3'h1;
    end else if (rc != 3'h0) begin
      rc <= (rc == 3'h6) ? 3'h0 : rc + 3'h1;
    end
  end
endmodule

/* tb_top.sv */
// Self-checking bench for the SDRAM command sequencer.
`timescale 1ns/1ns
`include "sdc_params.svh"
module tb_top;
  logic sys_clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_autopre = 0;
  logic [21:0] req_addr = 0;
  logic [127:0] req_wdata = 0;
  logic [31:0] rd_data, mem_dq_in, mem_dq_out, mdl_dq;
  logic req_ready, rd_valid, init_done, mem_clk_en, mem_dq_oe, mem_byte_mask;
  logic cs_n, ras_n, cas_n, we_n;
  logic [13:0] mem_addr;
  logic [3:0] cmd;
  int error_cnt = 0, check_count = 0, cyc = 0, nref = 0, npre = 0;
  int t_act = -99, t_ref = -99, t_pre = -99, t_mrs = -99, t_wr = -99;
  logic wr_ap = 0;
  logic ce = 1;
  always #4 sys_clk = ~sys_clk;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign mem_dq_in = mem_dq_oe ? mem_dq_out : mdl_dq;
  sdc_ctrl #(.PWRUP_CYC(20), .INIT_REFS(2)) sdc_ctrl_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_autopre(req_autopre), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
    .init_done(init_done), .mem_clk_en(mem_clk_en), .mem_chip_sel_n(cs_n),
    .mem_row_strobe_n(ras_n), .mem_col_strobe_n(cas_n),
    .mem_write_en_n(we_n), .mem_byte_mask(mem_byte_mask),
    .mem_addr(mem_addr), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
    .mem_dq_oe(mem_dq_oe));
  sdc_mem_model sdc_mem_model_i (.sys_clk(sys_clk), .cmd(cmd),
    .addr(mem_addr), .dq_w(mem_dq_out), .dq_r(mdl_dq));
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (ce) cyc++;
    if (rst_n && ce) case (cmd)
      `SDC_CMD_ACT, `SDC_CMD_REF: begin
        check(cyc - t_act >= 12, 1'b1);
        check(cyc - t_ref >= 12, 1'b1);
        check(cyc - t_mrs >= 2, 1'b1);
        if (wr_ap) check(cyc - t_wr - 3 >= 6, 1'b1);
        if (cmd == `SDC_CMD_ACT) check(cyc - t_pre >= 12, 1'b1);
        if (cmd == `SDC_CMD_REF && init_done === 1'b1)
          check(cyc - t_ref <= 1545, 1'b1);
        if (cmd == `SDC_CMD_ACT) t_act = cyc;
        else begin t_ref = cyc; nref++; end
        wr_ap = 0;
      end
      `SDC_CMD_PRE: begin
        check(cyc - t_act >= 12 || npre == 0, 1'b1);
        check(cyc - t_wr - 3 >= 2, 1'b1);
        t_pre = cyc;
        npre++;
      end
      `SDC_CMD_RD, `SDC_CMD_WR: begin
        check(cyc - t_act >= 3, 1'b1);
        check(mem_addr[10], req_autopre);
        if (cmd == `SDC_CMD_WR) begin t_wr = cyc; wr_ap = mem_addr[10]; end
      end
      `SDC_CMD_MRS: begin
        check(mem_addr, `SDC_MODE_WORD);
        check({mem_clk_en, 8'(nref), 8'(npre)}, {1'b1, 8'h2, 8'h1});
        t_mrs = cyc;
      end
      default: ;
    endcase
  end
  task automatic access(input logic wr, ap, input logic [21:0] a,
                        input logic [127:0] d);
    int i, n;
    @(negedge sys_clk);
    {req_valid, req_write, req_autopre} = {1'b1, wr, ap};
    {req_addr, req_wdata} = {a, d};
    #1;
    for (i = 0; i < 3000 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    if (i == 3000) begin check(1'b0, 1'b1); summarize(); end
    @(negedge sys_clk);
    req_valid = 0;
    n = 0;
    for (i = 0; i < 40 && !wr && n < 4; i++) begin
      @(negedge sys_clk);
      if (rd_valid === 1'b1) begin
        check(rd_data, d[n*32 +: 32]);
        n++;
      end
    end
    if (!wr) check(n, 4);
    if (!wr && n != 4) summarize();
  endtask
  task automatic t_init();
    int i;
    repeat (8) @(negedge sys_clk);
    rst_n = 1;
    for (i = 0; i < 500 && init_done !== 1'b1; i++) @(negedge sys_clk);
    check(init_done, 1'b1);
    if (init_done !== 1'b1) summarize();
    $display("test init done");
  endtask
  task automatic t_freeze();
    int i;
    logic [17:0] held;
    @(negedge sys_clk);
    for (i = 0; i < 3000 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    if (i == 3000) begin check(1'b0, 1'b1); summarize(); end
    ce = 0;
    req_valid = 1;
    held = {cmd, mem_addr};
    repeat (20) @(negedge sys_clk);
    check({cmd, mem_addr, rd_valid}, {held, 1'b0});
    req_valid = 0;
    ce = 1;
    $display("test freeze done");
  endtask
  task automatic t_rw(input logic ap, input logic [1:0] b);
    logic [127:0] d = {32'h0a0b0c0d, 32'h11223344, 32'hf0e1d2c3, 32'h5a5aa5a5};
    d = d ^ {4{30'h0, b}};
    access(1'b1, ap, {b, 12'h123, 8'h40}, d);
    access(1'b0, ap, {b, 12'h123, 8'h40}, d);
    $display("test read write done");
  endtask
  task automatic t_refresh();
    int n0 = nref;
    repeat (3200) @(negedge sys_clk);
    check(nref - n0 >= 2, 1'b1);
    check(mem_byte_mask, 1'b0);
    $display("test refresh done");
  endtask
  initial begin
    t_init();
    t_rw(1'b0, 2'h1);
    t_rw(1'b1, 2'h2);
    t_rw(1'b0, 2'h3);
    t_freeze();
    t_refresh();
    summarize();
  end
endmodule
